// ==== src/wiil_top.sv ====
// Wake pin configuration, wake detection and interrupt signalling of the system basis chip.
//
// What this block does
// - Pull field: none, pull-down or pull-up.
// - Both pull bits: pull follows detected level.
// - Cyclic sense samples during high-side on-time.
// - Measurement blocks fault, test, GPIO, wake.
// - Measurement disables pulls and gates wake signal.
// - Measurement ignores but keeps wake settings.
// - Measurement keeps wake status, clears level.
// - Sleep while measuring with only wake pin: flag, restart.
// - Static sense needs level stable 16 us.
// - Normal/stop: interrupt low for pulse width.
// - Interrupt high at least the minimum gap.
// - Interrupt never changes the operating mode.
// - Class bit: wake only or wake plus failures.
// - Wake class needs the source wake-enabled.
// - Bus timeout governed only by its mask.
// - Global class adds failures; level never interrupts.
// - Supply, watchdog, thermal, power-on bits never interrupt.
// - No pulse starts in restart, fail-safe or sleep.
// - Stop entry with wake bits set pulses.
// - Visible status refreshed at pulse falling edge.
// - Events latched until cleared; level is live, or the last committed sample under cyclic sense.
`timescale 1ns/1ps
module wiil_top import wiil_pkg::*; #(
	parameter logic [INT_CNT_W-1:0] PULSE_CYCLES = INT_CNT_W'(INT_PULSE_CYCLES),
	parameter logic [INT_CNT_W-1:0] GAP_CYCLES = INT_CNT_W'(INT_GAP_CYCLES)
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic clkEn,
	input wire wiil_mode_t chipMode,
	input wire logic wakePinLevel,
	input wire logic [1:0] wakePullControl,
	input wire logic wakeEnableControl,
	input wire logic cyclicSense,
	input wire logic highSideSwitchOn,
	input wire logic hvMeasureEnable,
	input wire logic faultOutputRequest,
	input wire logic faultOutTestOn,
	input wire logic gpioFunctionRequest,
	input wire wiil_wake_en_t wakeSourceEnable,
	input wire logic intGlobal,
	input wire logic busTimeoutIrqMask,
	input wire logic busWakeEvent,
	input wire logic busTimeoutEvent,
	input wire logic timerEvent,
	input wire logic gpioWakeEvent,
	input wire wiil_fail_t failEvents,
	input wire wiil_wake_a_t clearWakeA,
	input wire wiil_wake_b_t clearWakeB,
	input wire wiil_fail_t clearFail,
	input wire logic sleepRequest,
	input wire logic clearInvalidSleep,
	output logic interrupt_n,
	output logic pullUpOn,
	output logic pullDownOn,
	output logic faultOutputOn,
	output logic gpioFunctionOn,
	output logic wakeLevelStatus,
	output wiil_wake_a_t wakeEventStatusA,
	output wiil_wake_b_t wakeEventStatusB,
	output wiil_fail_t failStatus,
	output logic invalidSleepFlag,
	output logic restartRequest,
	output logic sleepGrant,
	output logic deviceWakeUp
);

	////////////////////////////////////////////////////////////////////////////
	// Decoding of the pulse modes and of set wake status, each used once.
	function automatic logic pulse_mode(input wiil_mode_t m);
		return m == MODE_NORMAL || m == MODE_STOP;
	endfunction

	function automatic logic any_wake(input wiil_wake_a_t a, input wiil_wake_b_t b);
		return (|a) || (|b);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Wake path gating and pull sources.
	logic measOn;
	logic gatedLevel;
	logic filtLevel;
	logic filtChange;
	logic pullUp_next;
	logic pullDown_next;

	assign measOn = hvMeasureEnable;
	assign gatedLevel = measOn ? 1'b0 : wakePinLevel;

	// While measuring, every alternate pin function is held off.
	assign faultOutputOn = !measOn && (faultOutputRequest || faultOutTestOn);
	assign gpioFunctionOn = !measOn && gpioFunctionRequest;

	// The pull field stays stored outside; it only loses its effect here.
	always_comb begin
		pullUp_next = 1'b0;
		pullDown_next = 1'b0;
		if (!measOn) begin
			unique case (wakePullControl)
				PULL_NONE: begin
					pullUp_next = 1'b0;
				end
				PULL_DOWN: begin
					pullDown_next = 1'b1;
				end
				PULL_UP: begin
					pullUp_next = 1'b1;
				end
				PULL_AUTO: begin
					pullUp_next = wakeLevelStatus;
					pullDown_next = !wakeLevelStatus;
				end
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			pullUpOn <= 1'b0;
			pullDownOn <= 1'b0;
		end else if (clkEn) begin
			pullUpOn <= pullUp_next;
			pullDownOn <= pullDown_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Static sense filter.
	wiil_wake_filter u_filter (
		.clock(clock),
		.rst_n(rst_n),
		.clkEn(clkEn),
		.clear(measOn),
		.levelIn(gatedLevel),
		.levelOut(filtLevel),
		.levelChange(filtChange)
	);

	////////////////////////////////////////////////////////////////////////////
	// Cyclic sense: the level seen during the high-side on-time is committed
	// when the on-time ends, and compared with the previous commit.
	logic hsOnPrev_reg;
	logic cycSample_reg;
	logic cycLevel_reg;
	logic cycValid_reg;
	logic cycChange;
	logic cycCommit;

	assign cycCommit = cyclicSense && !measOn && hsOnPrev_reg && !highSideSwitchOn;
	assign cycChange = cycCommit && cycValid_reg && (cycSample_reg != cycLevel_reg);

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			hsOnPrev_reg <= 1'b0;
			cycSample_reg <= 1'b0;
			cycLevel_reg <= 1'b0;
			cycValid_reg <= 1'b0;
		end else if (clkEn) begin
			hsOnPrev_reg <= highSideSwitchOn;
			if (highSideSwitchOn) begin
				cycSample_reg <= gatedLevel;
			end
			if (!cyclicSense || measOn) begin
				cycValid_reg <= 1'b0;
				cycLevel_reg <= 1'b0;
			end else if (cycCommit) begin
				cycLevel_reg <= cycSample_reg;
				cycValid_reg <= 1'b1;
			end
		end
	end

	// Live level, or the last cycle sample while cyclic sense runs.
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			wakeLevelStatus <= 1'b0;
		end else if (clkEn) begin
			if (measOn) begin
				wakeLevelStatus <= 1'b0;
			end else if (cyclicSense) begin
				wakeLevelStatus <= cycLevel_reg;
			end else begin
				wakeLevelStatus <= wakePinLevel;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Event collection.
	logic pinEvent;
	wiil_wake_a_t setWakeA;
	wiil_wake_b_t setWakeB;
	logic wakeIrq;
	logic failIrq;
	logic eventIrq;

	assign pinEvent = !measOn && wakeEnableControl && (cyclicSense ? cycChange : filtChange);

	always_comb begin
		setWakeA.busTimeout = busTimeoutEvent;
		setWakeA.busWake = busWakeEvent && wakeSourceEnable.busWakeEnable;
		setWakeA.timerWake = timerEvent && wakeSourceEnable.timerWakeEnable;
		setWakeA.wakePinWake = pinEvent;
		setWakeB.gpioWake = gpioWakeEvent && wakeSourceEnable.gpioIsWakeInput;
	end

	// Bus timeout answers to its own mask whatever the class bit says.
	assign wakeIrq = setWakeA.busWake || setWakeA.timerWake || setWakeA.wakePinWake
		|| setWakeB.gpioWake || (setWakeA.busTimeout && !busTimeoutIrqMask);
	// Only the general fault group interrupts; the reset-class bits never do.
	assign failIrq = intGlobal && (|failEvents.irqFaults);
	assign eventIrq = wakeIrq || failIrq;

	////////////////////////////////////////////////////////////////////////////
	// Latched status, set wins over a clear in the same cycle.
	wiil_wake_a_t wakeA_reg;
	wiil_wake_b_t wakeB_reg;
	wiil_fail_t fail_reg;
	wiil_wake_a_t wakeA_next;
	wiil_wake_b_t wakeB_next;
	wiil_fail_t fail_next;

	always_comb begin
		wakeA_next = (wakeA_reg & ~clearWakeA) | setWakeA;
		wakeB_next = (wakeB_reg & ~clearWakeB) | setWakeB;
		fail_next = (fail_reg & ~clearFail) | failEvents;
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			wakeA_reg <= WAKE_A_RESET;
			wakeB_reg <= WAKE_B_RESET;
			fail_reg <= FAIL_RESET;
		end else if (clkEn) begin
			wakeA_reg <= wakeA_next;
			wakeB_reg <= wakeB_next;
			fail_reg <= fail_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Pending request and pulse sequencing.
	logic pending_reg;
	logic prevStop_reg;
	logic stopEntry;
	logic pulseAllowed;
	logic pulseActive;
	logic pulseStart;

	assign pulseAllowed = pulse_mode(chipMode);
	assign stopEntry = chipMode == MODE_STOP && !prevStop_reg && any_wake(wakeA_reg, wakeB_reg);

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			prevStop_reg <= 1'b0;
		end else if (clkEn) begin
			prevStop_reg <= chipMode == MODE_STOP;
		end
	end

	// A request raised while a pulse or gap runs is simply kept until the
	// sequencer is idle again, so bursts merge into one further pulse.
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			pending_reg <= 1'b0;
		end else if (clkEn) begin
			if (!pulseAllowed) begin
				pending_reg <= 1'b0;
			end else if (eventIrq || stopEntry) begin
				pending_reg <= 1'b1;
			end else if (pulseStart) begin
				pending_reg <= 1'b0;
			end
		end
	end

	wiil_pulse_gen #(
		.PULSE_CYCLES(PULSE_CYCLES),
		.GAP_CYCLES(GAP_CYCLES)
	) u_pulse (
		.clock(clock),
		.rst_n(rst_n),
		.clkEn(clkEn),
		.request(pending_reg),
		.allowed(pulseAllowed),
		.pulseActive(pulseActive),
		.pulseStart(pulseStart)
	);

	// Push-pull output; this block only reports and never drives the mode.
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			interrupt_n <= 1'b1;
		end else if (clkEn) begin
			interrupt_n <= !(pulseActive || pulseStart);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Host-visible status: snapshot taken as the pulse falls, clears apply
	// at once so a re-read after clearing shows the bit gone.
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			wakeEventStatusA <= WAKE_A_RESET;
			wakeEventStatusB <= WAKE_B_RESET;
			failStatus <= FAIL_RESET;
		end else if (clkEn) begin
			if (pulseStart) begin
				wakeEventStatusA <= wakeA_next;
				wakeEventStatusB <= wakeB_next;
				failStatus <= fail_next;
			end else begin
				wakeEventStatusA <= wakeEventStatusA & ~clearWakeA;
				wakeEventStatusB <= wakeEventStatusB & ~clearWakeB;
				failStatus <= failStatus & ~clearFail;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Sleep request check and wake-up from low-power modes.
	logic pinOnlySource;
	logic badSleep;

	assign pinOnlySource = wakeEnableControl && !wakeSourceEnable.busWakeEnable
		&& !wakeSourceEnable.timerWakeEnable && !wakeSourceEnable.gpioIsWakeInput;
	assign badSleep = sleepRequest && measOn && pinOnlySource;

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			invalidSleepFlag <= 1'b0;
			restartRequest <= 1'b0;
			sleepGrant <= 1'b0;
		end else if (clkEn) begin
			restartRequest <= badSleep;
			sleepGrant <= sleepRequest && !badSleep;
			if (badSleep) begin
				invalidSleepFlag <= 1'b1;
			end else if (clearInvalidSleep) begin
				invalidSleepFlag <= 1'b0;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			deviceWakeUp <= 1'b0;
		end else if (clkEn) begin
			deviceWakeUp <= (chipMode == MODE_SLEEP || chipMode == MODE_FAILSAFE) && wakeIrq;
		end
	end

endmodule // wiil_top

// ==== src/wiil_pkg.sv ====
// Shared constants, modes and carrier types of the wake input and interrupt logic.
package wiil_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Clock and timing.
	localparam int CLOCK_PERIOD_NS = 10;
	localparam int WAKE_FILTER_TIME_NS = 16000;
	// A nominal filter time lands inside the 13 to 20 microsecond window.
	localparam int WAKE_FILTER_CYCLES = WAKE_FILTER_TIME_NS / CLOCK_PERIOD_NS;
	localparam int WAKE_FILTER_W = 11;
	localparam int INT_PULSE_TIME_NS = 100000;
	localparam int INT_GAP_TIME_NS = 100000;
	localparam int INT_PULSE_CYCLES = INT_PULSE_TIME_NS / CLOCK_PERIOD_NS;
	localparam int INT_GAP_CYCLES = INT_GAP_TIME_NS / CLOCK_PERIOD_NS;
	localparam int INT_CNT_W = 14;

	////////////////////////////////////////////////////////////////////////////
	// Wake pull field encodings.
	localparam logic [1:0] PULL_NONE = 2'h0;
	localparam logic [1:0] PULL_DOWN = 2'h1;
	localparam logic [1:0] PULL_UP = 2'h2;
	localparam logic [1:0] PULL_AUTO = 2'h3;

	////////////////////////////////////////////////////////////////////////////
	// Chip operating modes, driven by the mode machine outside this block.
	typedef enum logic [2:0] {
		MODE_INIT,
		MODE_NORMAL,
		MODE_STOP,
		MODE_RESTART,
		MODE_FAILSAFE,
		MODE_SLEEP
	} wiil_mode_t;

	////////////////////////////////////////////////////////////////////////////
	// Status carriers.
	typedef struct packed {
		logic busTimeout;
		logic busWake;
		logic timerWake;
		logic wakePinWake;
	} wiil_wake_a_t;

	typedef struct packed {
		logic gpioWake;
	} wiil_wake_b_t;

	typedef struct packed {
		logic [7:0] irqFaults;
		logic mainSupplyUndervoltage;
		logic watchdogFault;
		logic mainSupplyShort;
		logic thermalShutdownFlag;
		logic thermalSafeFlag;
		logic failure;
		logic powerOn;
		logic [1:0] deviceStateBits;
	} wiil_fail_t;

	localparam wiil_wake_a_t WAKE_A_RESET = '{default: 1'b0};
	localparam wiil_wake_b_t WAKE_B_RESET = '{default: 1'b0};
	localparam wiil_fail_t FAIL_RESET = '{default: '0};

	// Wake enables of the non-pin sources.
	typedef struct packed {
		logic busWakeEnable;
		logic timerWakeEnable;
		logic gpioIsWakeInput;
	} wiil_wake_en_t;

endpackage

// ==== src/wiil_wake_filter.sv ====
// Static-sense glitch filter on the wake pin level.
`timescale 1ns/1ps
module wiil_wake_filter import wiil_pkg::*; (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic clkEn,
	input wire logic clear,
	input wire logic levelIn,
	output logic levelOut,
	output logic levelChange
);

	logic [WAKE_FILTER_W-1:0] count_reg;
	localparam logic [WAKE_FILTER_W-1:0] FILTER_LAST = WAKE_FILTER_W'(WAKE_FILTER_CYCLES - 1);

	////////////////////////////////////////////////////////////////////////////
	// A new level is accepted only after it held for the whole filter time.
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			count_reg <= '0;
		end else if (clkEn) begin
			if (clear || levelIn == levelOut) begin
				count_reg <= '0;
			end else if (count_reg == FILTER_LAST) begin
				count_reg <= '0;
			end else begin
				count_reg <= count_reg + 1'b1;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			levelOut <= 1'b0;
			levelChange <= 1'b0;
		end else if (clkEn) begin
			levelChange <= 1'b0;
			if (clear) begin
				levelOut <= 1'b0;
			end else if (levelIn != levelOut && count_reg == FILTER_LAST) begin
				levelOut <= levelIn;
				levelChange <= 1'b1;
			end
		end
	end

endmodule // wiil_wake_filter

// ==== src/wiil_pulse_gen.sv ====
// Interrupt pulse and minimum gap sequencer.
`timescale 1ns/1ps
module wiil_pulse_gen import wiil_pkg::*; #(
	parameter logic [INT_CNT_W-1:0] PULSE_CYCLES = INT_CNT_W'(INT_PULSE_CYCLES),
	parameter logic [INT_CNT_W-1:0] GAP_CYCLES = INT_CNT_W'(INT_GAP_CYCLES)
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic clkEn,
	input wire logic request,
	input wire logic allowed,
	output logic pulseActive,
	output logic pulseStart
);

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_PULSE,
		ST_GAP
	} wiil_pulse_st_t;

	wiil_pulse_st_t state_reg;
	logic [INT_CNT_W-1:0] count_reg;

	assign pulseActive = (state_reg == ST_PULSE);
	assign pulseStart = clkEn && state_reg == ST_IDLE && request && allowed;

	////////////////////////////////////////////////////////////////////////////
	// A running pulse always completes and is followed by the full gap, even
	// if the mode changes meanwhile, so the host never sees a runt pulse.
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			state_reg <= ST_IDLE;
			count_reg <= '0;
		end else if (clkEn) begin
			unique case (state_reg)
				ST_IDLE: begin
					if (request && allowed) begin
						// The start cycle already drives the pin low, so it is the first pulse cycle.
						count_reg <= {{(INT_CNT_W-1){1'b0}}, 1'b1};
						state_reg <= ST_PULSE;
					end else begin
						count_reg <= '0;
					end
				end
				ST_PULSE: begin
					if (count_reg == PULSE_CYCLES - 1'b1) begin
						count_reg <= '0;
						state_reg <= ST_GAP;
					end else begin
						count_reg <= count_reg + 1'b1;
					end
				end
				ST_GAP: begin
					if (count_reg == GAP_CYCLES - 1'b1) begin
						count_reg <= '0;
						state_reg <= ST_IDLE;
					end else begin
						count_reg <= count_reg + 1'b1;
					end
				end
			endcase
		end
	end

endmodule // wiil_pulse_gen

// ==== tb/wiil_top_asserts.sv ====
// Concurrent checks on the ports of the wake input and interrupt block.
`timescale 1ns/1ps
module wiil_top_asserts import wiil_pkg::*; #(
	parameter logic [INT_CNT_W-1:0] PULSE_CYCLES = INT_CNT_W'(INT_PULSE_CYCLES),
	parameter logic [INT_CNT_W-1:0] GAP_CYCLES = INT_CNT_W'(INT_GAP_CYCLES)
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic clkEn,
	input wire wiil_mode_t chipMode,
	input wire logic [1:0] wakePullControl,
	input wire logic wakeEnableControl,
	input wire logic hvMeasureEnable,
	input wire logic faultOutputRequest,
	input wire logic faultOutTestOn,
	input wire logic gpioFunctionRequest,
	input wire wiil_wake_en_t wakeSourceEnable,
	input wire logic busWakeEvent,
	input wire wiil_wake_a_t clearWakeA,
	input wire logic sleepRequest,
	input wire logic interrupt_n,
	input wire logic pullUpOn,
	input wire logic pullDownOn,
	input wire logic faultOutputOn,
	input wire logic gpioFunctionOn,
	input wire logic wakeLevelStatus,
	input wire wiil_wake_a_t wakeEventStatusA,
	input wire logic invalidSleepFlag,
	input wire logic restartRequest,
	input wire logic sleepGrant
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	////////////////////////////////////////////////////////////////////////////
	// Pulse and gap lengths are too long for a repetition, so they are counted here.
	logic [INT_CNT_W-1:0] lowCnt_reg;
	logic [INT_CNT_W-1:0] highCnt_reg;
	always_ff @(posedge clock) begin
		if (!rst_n || interrupt_n) lowCnt_reg <= '0;
		else if (clkEn) lowCnt_reg <= lowCnt_reg + 1'b1;
	end
	// The gap counter starts full so that a first pulse after reset is not taken for a short gap.
	always_ff @(posedge clock) begin
		if (!rst_n) highCnt_reg <= GAP_CYCLES;
		else if (!interrupt_n) highCnt_reg <= '0;
		else if (clkEn && highCnt_reg < GAP_CYCLES) highCnt_reg <= highCnt_reg + 1'b1;
	end

	////////////////////////////////////////////////////////////////////////////
	chk_pulse_width: assert property (interrupt_n && lowCnt_reg != '0 |-> lowCnt_reg == PULSE_CYCLES)
		else $error("interrupt pulse width wrong");
	chk_gap_min: assert property (!interrupt_n && $past(interrupt_n) |-> highCnt_reg >= GAP_CYCLES)
		else $error("interrupt gap too short");
	chk_mode_quiet: assert property ($fell(interrupt_n) |-> $past(chipMode) inside {MODE_NORMAL, MODE_STOP})
		else $error("interrupt pulse in a quiet mode");
	chk_fixed_pulls: assert property (clkEn && !hvMeasureEnable && wakePullControl != PULL_AUTO |=>
		pullUpOn == ($past(wakePullControl) == PULL_UP) && pullDownOn == ($past(wakePullControl) == PULL_DOWN))
		else $error("pull sources do not match field");
	chk_auto_pull: assert property (clkEn && !hvMeasureEnable && wakePullControl == PULL_AUTO |=>
		pullUpOn == $past(wakeLevelStatus) && pullDownOn == !$past(wakeLevelStatus))
		else $error("automatic pull does not follow level");
	chk_measure_off: assert property (clkEn && hvMeasureEnable |=> !pullUpOn && !pullDownOn && !wakeLevelStatus)
		else $error("wake pin active while measuring");
	chk_alt_gated: assert property (faultOutputOn == ((faultOutputRequest || faultOutTestOn) && !hvMeasureEnable) &&
		gpioFunctionOn == (gpioFunctionRequest && !hvMeasureEnable))
		else $error("pin functions not gated by measurement");
	chk_sleep_reply: assert property (clkEn && sleepRequest |=> restartRequest != sleepGrant)
		else $error("sleep request answer wrong");
	chk_invalid_sleep: assert property (clkEn && sleepRequest && hvMeasureEnable && wakeEnableControl &&
		wakeSourceEnable == '0 |=> restartRequest && invalidSleepFlag)
		else $error("invalid sleep not flagged");
	chk_clear_wake: assert property (clkEn && clearWakeA.busWake && !busWakeEvent |=> !wakeEventStatusA.busWake)
		else $error("wake status bit not cleared");
endmodule // wiil_top_asserts

bind wiil_top wiil_top_asserts #(.PULSE_CYCLES(PULSE_CYCLES), .GAP_CYCLES(GAP_CYCLES)) wiil_top_asserts_inst (.*);

// ==== tb/tb_host.sv ====
// Host model that answers each interrupt by reading and clearing the wake status.
`timescale 1ns/1ps
module tb_host import wiil_pkg::*; (
	input wire logic clock,
	input wire logic interrupt_n,
	input wire wiil_wake_a_t statusA,
	input wire wiil_wake_b_t statusB,
	output wiil_wake_a_t clearA,
	output wiil_wake_b_t clearB,
	output int pulseCount,
	output wiil_wake_a_t firstRead,
	output wiil_wake_a_t secondRead
);
	initial begin
		{clearA, clearB, firstRead, secondRead} = '0;
		pulseCount = 0;
	end
	// The status is refreshed only at the falling edge, so reading earlier would see stale bits.
	always begin
		@(negedge interrupt_n);
		pulseCount++;
		@(negedge clock);
		firstRead = statusA;
		clearA = statusA;
		clearB = statusB;
		@(negedge clock);
		{clearA, clearB} = '0;
		@(negedge clock);
		secondRead = statusA;
	end
endmodule // tb_host

// ==== tb/tb_top.sv ====
// Self-checking bench of the wake input and interrupt logic.
`timescale 1ns/1ps
module tb_top import wiil_pkg::*; ;
	typedef struct packed {logic [1:0] ctl; logic hv; logic lvl; logic glob; logic mask; logic [2:0] en;
		logic [2:0] ev; logic [2:0] exp;} wiil_row_t;
	logic clock = 1'b0, rst_n = 1'b0, clkEn = 1'b1, wakePinLevel = 1'b0, wakeEnableControl = 1'b0;
	logic cyclicSense = 1'b0, highSideSwitchOn = 1'b0, hvMeasureEnable = 1'b0, faultOutputRequest = 1'b1;
	logic faultOutTestOn = 1'b0, gpioFunctionRequest = 1'b1, intGlobal = 1'b0, busTimeoutIrqMask = 1'b0;
	logic busWakeEvent = 1'b0, busTimeoutEvent = 1'b0, timerEvent = 1'b0, gpioWakeEvent = 1'b0;
	logic sleepRequest = 1'b0, clearInvalidSleep = 1'b0, woke = 1'b0;
	logic [1:0] wakePullControl = PULL_NONE;
	wiil_mode_t chipMode = MODE_NORMAL;
	wiil_wake_en_t wakeSourceEnable = '0;
	wiil_fail_t failEvents = '0, clearFail = '0, failStatus;
	wiil_wake_a_t clearWakeA, wakeEventStatusA, firstRead, secondRead;
	wiil_wake_b_t clearWakeB, wakeEventStatusB;
	logic interrupt_n, pullUpOn, pullDownOn, faultOutputOn, gpioFunctionOn, wakeLevelStatus;
	logic invalidSleepFlag, restartRequest, sleepGrant, deviceWakeUp;
	int pulseCount, err_count = 0, total_checks = 0;
	wiil_mode_t quiet [4] = '{MODE_INIT, MODE_RESTART, MODE_FAILSAFE, MODE_SLEEP};
	wiil_row_t rows [10] = '{
		'{2'h0, 1'h0, 1'h0, 1'h0, 1'h0, 3'h4, 3'h1, 3'h4}, '{2'h1, 1'h0, 1'h0, 1'h0, 1'h0, 3'h0, 3'h1, 3'h1},
		'{2'h2, 1'h0, 1'h0, 1'h0, 1'h0, 3'h0, 3'h2, 3'h6}, '{2'h3, 1'h0, 1'h1, 1'h1, 1'h1, 3'h0, 3'h2, 3'h2},
		'{2'h3, 1'h0, 1'h0, 1'h0, 1'h0, 3'h2, 3'h3, 3'h5}, '{2'h0, 1'h0, 1'h0, 1'h0, 1'h0, 3'h1, 3'h4, 3'h4},
		'{2'h2, 1'h1, 1'h0, 1'h0, 1'h0, 3'h0, 3'h5, 3'h0}, '{2'h3, 1'h1, 1'h1, 1'h1, 1'h0, 3'h0, 3'h5, 3'h4},
		'{2'h0, 1'h0, 1'h0, 1'h1, 1'h0, 3'h0, 3'h6, 3'h0}, '{2'h0, 1'h0, 1'h0, 1'h1, 1'h0, 3'h0, 3'h7, 3'h0}};

	wiil_top #(.PULSE_CYCLES(14'h0008), .GAP_CYCLES(14'h0006)) wiil_top_inst (.*);
	tb_host tb_host_inst (.clock, .interrupt_n, .statusA(wakeEventStatusA), .statusB(wakeEventStatusB),
		.clearA(clearWakeA), .clearB(clearWakeB), .pulseCount, .firstRead, .secondRead);

	always #5 clock = ~clock;
	always @(posedge clock) if (deviceWakeUp === 1'b1) woke <= 1'b1;

	////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected at %0t: %s got %0h want %0h", $time, what, seen, exp);
		end
	endtask
	task automatic test_done();
		$display("checks %0d, mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clock);
	endtask
	task automatic fire(input logic [2:0] ev);
		@(negedge clock);
		case (ev)
			3'h1: busWakeEvent = 1'b1;
			3'h2: busTimeoutEvent = 1'b1;
			3'h3: timerEvent = 1'b1;
			3'h4: gpioWakeEvent = 1'b1;
			3'h5: failEvents.irqFaults = 8'h01;
			3'h6: failEvents.watchdogFault = 1'b1;
			3'h7: failEvents.powerOn = 1'b1;
			default: ;
		endcase
		@(negedge clock);
		{busWakeEvent, busTimeoutEvent, timerEvent, gpioWakeEvent} = 4'h0;
		failEvents = '0;
	endtask
	// Pulses are counted by the host model so the bench never reads the design's own counters.
	task automatic expectPulses(input logic [31:0] n, input int w);
		int p;
		p = pulseCount;
		cyc(w);
		check(pulseCount - p, n, "pulse count");
	endtask
	task automatic hsOn();
		highSideSwitchOn = 1'b1;
		cyc(4);
		highSideSwitchOn = 1'b0;
	endtask

	initial begin
		repeat (20000) @(posedge clock);
		err_count++;
		$display("unexpected at %0t: watchdog expired", $time);
		test_done();
	end

	////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (20) @(negedge clock);
		rst_n = 1'b1;
		cyc(2);
		foreach (rows[i]) begin
			{wakePullControl, hvMeasureEnable, wakePinLevel, intGlobal, busTimeoutIrqMask} = {rows[i].ctl,
				rows[i].hv, rows[i].lvl, rows[i].glob, rows[i].mask};
			wakeSourceEnable = rows[i].en;
			cyc(3);
			check({pullUpOn, pullDownOn}, rows[i].exp[1:0], "pulls");
			check(wakeLevelStatus, rows[i].lvl & ~rows[i].hv, "level");
			check({faultOutputOn, gpioFunctionOn}, {2{~rows[i].hv}}, "alt pins");
			fire(rows[i].ev);
			expectPulses(rows[i].exp[2], 30);
			$display("row %0d done", i);
		end
		wakeSourceEnable = 3'h4;
		intGlobal = 1'b0;
		fire(3'h1);
		cyc(4);
		fire(3'h1);
		fire(3'h1);
		expectPulses(32'h1, 40);
		check(failStatus, 32'h284, "fail status");
		$display("merge test done");
		foreach (quiet[i]) begin
			chipMode = quiet[i];
			fire(3'h1);
			expectPulses(32'h0, 30);
		end
		check(woke, 1'b1, "wake from sleep");
		chipMode = MODE_STOP;
		expectPulses(32'h1, 30);
		check(firstRead, 32'h4, "stop entry status");
		check(secondRead, 32'h0, "status after clear");
		chipMode = MODE_NORMAL;
		$display("mode test done");
		{hvMeasureEnable, wakeEnableControl, sleepRequest} = 3'h7;
		wakeSourceEnable = '0;
		@(negedge clock);
		sleepRequest = 1'b0;
		check({restartRequest, invalidSleepFlag, sleepGrant}, 32'h6, "bad sleep");
		clearInvalidSleep = 1'b1;
		wakeSourceEnable = 3'h4;
		@(negedge clock);
		{clearInvalidSleep, sleepRequest} = 2'h1;
		@(negedge clock);
		sleepRequest = 1'b0;
		check({restartRequest, invalidSleepFlag, sleepGrant}, 32'h1, "sleep");
		$display("sleep test done");
		{faultOutputRequest, faultOutTestOn} = 2'h1;
		wakePinLevel = 1'b1;
		expectPulses(32'h0, 2100);
		check(faultOutputOn, 1'b0, "fault test");
		wakePinLevel = 1'b0;
		cyc(5);
		hvMeasureEnable = 1'b0;
		cyc(5);
		check(faultOutputOn, 1'b1, "fault test");
		wakePinLevel = 1'b1;
		cyc(1250);
		wakePinLevel = 1'b0;
		expectPulses(32'h0, 2100);
		wakePinLevel = 1'b1;
		expectPulses(32'h1, 2100);
		check(firstRead, 32'h1, "pin event");
		$display("static sense done");
		cyclicSense = 1'b1;
		hsOn();
		wakePinLevel = 1'b0;
		cyc(20);
		wakePinLevel = 1'b1;
		cyc(5);
		hsOn();
		expectPulses(32'h0, 30);
		wakePinLevel = 1'b0;
		hsOn();
		expectPulses(32'h1, 30);
		$display("cyclic sense done");
		wakePullControl = PULL_UP;
		fire(3'h1);
		cyc(4);
		rst_n = 1'b0;
		cyc(2);
		check({interrupt_n, pullUpOn, pullDownOn, wakeEventStatusA, wakeEventStatusB, failStatus}, 32'h1000000,
			"reset values");
		rst_n = 1'b1;
		cyc(3);
		$display("reset test done");
		test_done();
	end
endmodule // tb_top
